// File: rtl/qdc_command_control.sv
// Purpose: Serial slave with command register, latch loading, power-down, GPIO
// Assumes: spiSclk, spiCsN, spiSdi sampled on clk; clk much faster than spiSclk
// Notes:   Software reset clears register state like rst_n but only for one cycle; input-sampling flops and sdoEn_q keep following their inputs
`timescale 1ns/10ps
`include "qdc_params.svh"
module qdc_command_control #(
    parameter int CHANNELS = 4,
    parameter int DATA_W   = 16
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // Serial link from host
    input  wire logic                spiSclk,
    input  wire logic                spiCsN,
    input  wire logic                spiSdi,
    output logic                     serialOutPin,
    output logic                     serialOutEn,
    // Load strobe, active low
    input  wire logic                latchLoadStrobePinN,
    // General-purpose open-drain pins
    input  wire logic [1:0]          gpioIn,
    output logic      [1:0]          gpioOut,
    output logic      [1:0]          gpioOe,
    // Converter side
    output logic [CHANNELS-1:0][DATA_W-1:0] dacLatch,
    output logic [CHANNELS-1:0]      chanPowerDown
);
    import qdc_pkg::*;

    initial begin
        if (CHANNELS != 4 || DATA_W != 16) begin
            $error("qdc_command_control supports 4 channels of 16 bits only");
        end
    end

    // Serial front end state
    logic                 sclkPrev_q, sclkPrev_d;
    logic [23:0]          shiftIn_q, shiftIn_d;
    logic [15:0]          shiftOut_q, shiftOut_d;
    logic [4:0]           bitCnt_q, bitCnt_d;
    logic                 sdo_q, sdo_d;
    logic                 sdoEn_q, sdoEn_d;
    logic                 csPrev_q, csPrev_d;
    qdc_state_e           state_q, state_d;
    // Register state
    logic [15:0]          cmd_q, cmd_d;
    logic [15:0]          mon_q, mon_d;
    logic [CHANNELS-1:0][15:0] inReg_q, inReg_d;
    logic [CHANNELS-1:0][15:0] latch_q, latch_d;
    logic [CHANNELS-1:0]  touched_q, touched_d;
    logic [15:0]          readData_q, readData_d;
    logic                 strobePrev_q, strobePrev_d;
    logic                 swReset_q, swReset_d;
    logic [1:0]           gpioSamp_q, gpioSamp_d;
    logic [1:0]           gpioOe_q, gpioOe_d;
    logic                 frameEnd;
    logic [3:0]           fAddr;
    logic                 fRead;
    logic [15:0]          fData;
    logic                 loadNow;
    qdc_frame_s           frame;

    // Frame decode
    always_comb begin
        frame = qdc_frame_s'(shiftIn_q);
        fRead = frame.readReq;
        fAddr = frame.addr;
        fData = frame.data;
    end

    // Serial shifter: sample on rising, shift out on falling sclk
    always_comb begin
        sclkPrev_d = spiSclk;
        csPrev_d   = spiCsN;
        shiftIn_d  = shiftIn_q;
        shiftOut_d = shiftOut_q;
        bitCnt_d   = bitCnt_q;
        sdo_d      = sdo_q;
        sdoEn_d    = !spiCsN && !cmd_q[`QDC_BIT_DSDO];
        state_d    = state_q;
        frameEnd   = 1'b0;
        unique case (state_q)
            QDC_IDLE: begin
                if (!spiCsN) begin
                    state_d  = QDC_SHIFT;
                    bitCnt_d = 5'h00;
                    sdo_d    = readData_q[15];
                    shiftOut_d = readData_q;
                end
            end
            QDC_SHIFT: begin
                if (spiCsN) begin
                    state_d = QDC_DONE;
                end else if (spiSclk && !sclkPrev_q) begin
                    shiftIn_d = {shiftIn_q[22:0], spiSdi};
                    if (bitCnt_q != 5'h1F) begin
                        bitCnt_d = bitCnt_q + 5'h01;
                    end
                end else if (!spiSclk && sclkPrev_q) begin
                    shiftOut_d = {shiftOut_q[14:0], 1'b0};
                    sdo_d      = shiftOut_q[14];
                end
            end
            QDC_DONE: begin
                state_d  = QDC_IDLE;
                frameEnd = (bitCnt_q == 5'(`QDC_FRAME_BITS));
            end
        endcase
    end

    // Register file, loading and self-clearing bits
    always_comb begin
        cmd_d        = cmd_q;
        mon_d        = mon_q;
        inReg_d      = inReg_q;
        latch_d      = latch_q;
        touched_d    = touched_q;
        readData_d   = readData_q;
        strobePrev_d = latchLoadStrobePinN;
        gpioSamp_d   = gpioIn;
        swReset_d    = 1'b0;
        loadNow      = 1'b0;
        if (frameEnd && !fRead) begin
            if (fAddr == `QDC_ADDR_CMD) begin
                cmd_d = (fData & `QDC_CMD_WMASK) | (cmd_q & ~`QDC_CMD_WMASK);
                cmd_d[`QDC_BIT_NOP] = 1'b0;
                if (!latchLoadStrobePinN) begin
                    cmd_d[`QDC_BIT_SYNC_LOAD] = 1'b0;
                end
                swReset_d = fData[`QDC_BIT_RST];
            end else if (fAddr == `QDC_ADDR_MON) begin
                mon_d = fData & `QDC_MON_MASK;
            end
        end
        // Strobe falling edge or load bit triggers transfer
        loadNow = (strobePrev_q && !latchLoadStrobePinN)
                || (cmd_q[`QDC_BIT_SYNC_LOAD] && latchLoadStrobePinN);
        if (loadNow) begin
            cmd_d[`QDC_BIT_SYNC_LOAD] = 1'b0;
        end
        // Pin enable follows the next command value so it leaves a flop
        gpioOe_d = ~cmd_d[`QDC_BIT_GP1:`QDC_BIT_GP0];
        for (int i = 0; i < CHANNELS; i++) begin
            if (loadNow && touched_q[i]) begin
                latch_d[i]   = inReg_q[i];
                touched_d[i] = 1'b0;
            end else if (!latchLoadStrobePinN) begin
                latch_d[i]   = inReg_q[i];
                touched_d[i] = 1'b0;
            end
            // Set wins over clear: a write in the load cycle stays pending
            if (frameEnd && !fRead && fAddr == `QDC_ADDR_DAC0 + 4'(i)) begin
                inReg_d[i]   = fData & `QDC_DAC_MASK;
                touched_d[i] = 1'b1;
            end
        end
        if (frameEnd && fRead) begin
            readData_d = 16'h0000;
            if (fAddr == `QDC_ADDR_CMD) begin
                readData_d = cmd_q;
                readData_d[`QDC_BIT_RSVD] = 1'b0;
                readData_d[`QDC_BIT_NOP]  = 1'b0;
                readData_d[`QDC_BIT_GP1]  = gpioSamp_q[1];
                readData_d[`QDC_BIT_GP0]  = gpioSamp_q[0];
            end else if (fAddr == `QDC_ADDR_MON) begin
                readData_d = mon_q;
            end else if (fAddr >= `QDC_ADDR_DAC0 && fAddr <= `QDC_ADDR_DAC3) begin
                readData_d = cmd_q[`QDC_BIT_SRC] ? latch_q[2'(fAddr)]
                                                 : inReg_q[2'(fAddr)];
            end
        end
    end

    // Registers; software reset acts like the reset pin except for the input-sampling flops and sdoEn_q
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkPrev_q   <= 1'b0;
            csPrev_q     <= 1'b1;
            shiftIn_q    <= 24'h000000;
            shiftOut_q   <= 16'h0000;
            bitCnt_q     <= 5'h00;
            sdo_q        <= 1'b0;
            sdoEn_q      <= 1'b0;
            state_q      <= QDC_IDLE;
            cmd_q        <= `QDC_CMD_RESET;
            mon_q        <= 16'h0000;
            inReg_q      <= '0;
            latch_q      <= '0;
            touched_q    <= '0;
            readData_q   <= 16'h0000;
            strobePrev_q <= 1'b1;
            swReset_q    <= 1'b0;
            gpioSamp_q   <= 2'h3;
            gpioOe_q     <= 2'h0;
        end else if (swReset_q) begin
            sclkPrev_q   <= sclkPrev_d;
            csPrev_q     <= csPrev_d;
            shiftIn_q    <= 24'h000000;
            shiftOut_q   <= 16'h0000;
            bitCnt_q     <= 5'h00;
            sdo_q        <= 1'b0;
            sdoEn_q      <= sdoEn_d;
            state_q      <= QDC_IDLE;
            cmd_q        <= `QDC_CMD_RESET;
            mon_q        <= 16'h0000;
            inReg_q      <= '0;
            latch_q      <= '0;
            touched_q    <= '0;
            readData_q   <= 16'h0000;
            strobePrev_q <= strobePrev_d;
            swReset_q    <= 1'b0;
            gpioSamp_q   <= gpioSamp_d;
            gpioOe_q     <= 2'h0;
        end else begin
            sclkPrev_q   <= sclkPrev_d;
            csPrev_q     <= csPrev_d;
            shiftIn_q    <= shiftIn_d;
            shiftOut_q   <= shiftOut_d;
            bitCnt_q     <= bitCnt_d;
            sdo_q        <= sdo_d;
            sdoEn_q      <= sdoEn_d;
            state_q      <= state_d;
            cmd_q        <= cmd_d;
            mon_q        <= mon_d;
            inReg_q      <= inReg_d;
            latch_q      <= latch_d;
            touched_q    <= touched_d;
            readData_q   <= readData_d;
            strobePrev_q <= strobePrev_d;
            swReset_q    <= swReset_d;
            gpioSamp_q   <= gpioSamp_d;
            gpioOe_q     <= gpioOe_d;
        end
    end

    // Outputs, all from flip-flops except gpioOut, tied to zero
    assign serialOutPin  = sdo_q;
    assign serialOutEn   = sdoEn_q;
    assign dacLatch      = latch_q;
    assign gpioOut       = 2'h0; // Open drain: only ever pulls low
    assign gpioOe        = gpioOe_q;
    assign chanPowerDown = {{2{cmd_q[`QDC_BIT_PD_HIGH]}},
                            {2{cmd_q[`QDC_BIT_PD_LOW]}}};
endmodule // qdc_command_control

// File: inc/qdc_params.svh
// Purpose: Constants for the quad converter command control block
// Assumes: 24-bit serial frames, 16-bit registers
// Notes:   Field positions, addresses and reset values
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH
`define QDC_FRAME_BITS      24
`define QDC_RW_POS          23
`define QDC_ADDR_HI         19
`define QDC_ADDR_LO         16
`define QDC_ADDR_CMD        4'h0
`define QDC_ADDR_MON        4'h1
`define QDC_ADDR_DAC0       4'h4
`define QDC_ADDR_DAC3       4'h7
`define QDC_CMD_RESET       16'h033C
`define QDC_BIT_SRC         15
`define QDC_BIT_SYNC_LOAD   14
`define QDC_BIT_RST         13
`define QDC_BIT_PD_LOW      12
`define QDC_BIT_PD_HIGH     11
`define QDC_BIT_RSVD        10
`define QDC_BIT_GP1         9
`define QDC_BIT_GP0         8
`define QDC_BIT_DSDO        7
`define QDC_BIT_NOP         6
`define QDC_CMD_WMASK       16'hFBBC
`define QDC_DAC_MASK        16'hFFFC
`define QDC_MON_MASK        16'hF800
`endif

// File: inc/qdc_pkg.sv
// Purpose: Types for the quad converter command control block
// Assumes: qdc_params.svh gives the numbers
// Notes:   Frame fields travel as one packed struct
package qdc_pkg;
    typedef struct packed {
        logic       readReq;
        logic [2:0] zeros;
        logic [3:0] addr;
        logic [15:0] data;
    } qdc_frame_s;
    typedef enum logic [1:0] {
        QDC_IDLE,
        QDC_SHIFT,
        QDC_DONE
    } qdc_state_e;
endpackage

// File: verification/qdc_command_control_chk.sv
// Purpose: Port-level checks of the command control block
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound to every instance of the design
`timescale 1ns/10ps
module qdc_command_control_chk #(
    parameter int CHANNELS = 4,
    parameter int DATA_W   = 16
) (
    // Clock and reset
    input wire logic                            clk,
    input wire logic                            rst_n,
    // Serial link
    input wire logic                            spiSclk,
    input wire logic                            spiCsN,
    input wire logic                            serialOutPin,
    input wire logic                            serialOutEn,
    // Pins and converter side
    input wire logic                            latchLoadStrobePinN,
    input wire logic [1:0]                      gpioOut,
    input wire logic [1:0]                      gpioOe,
    input wire logic [CHANNELS-1:0][DATA_W-1:0] dacLatch,
    input wire logic [CHANNELS-1:0]             chanPowerDown
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Frame select idle and serial clock held high
    sequence s_csIdle; spiCsN[*5]; endsequence
    sequence s_sclkHigh; spiSclk[*3]; endsequence
    AST_SDO_OFF_IDLE: assert property (s_csIdle |-> !serialOutEn)
        else $error("serial out enabled outside a frame");
    AST_SDO_STEADY: assert property (s_sclkHigh |-> $stable(serialOutPin))
        else $error("serial out moved while serial clock high");
    AST_GPIO_OPEN_DRAIN: assert property (gpioOut == 2'b00)
        else $error("general-purpose pin driven high");
    AST_GPIO_FRAME_END: assert property ($changed(gpioOe) |-> spiCsN)
        else $error("pin enable changed inside a frame");
    AST_PD_LOW_PAIR: assert property (chanPowerDown[0] == chanPowerDown[1])
        else $error("low pair power-down split");
    AST_PD_HIGH_PAIR: assert property (chanPowerDown[2] == chanPowerDown[3])
        else $error("high pair power-down split");
    AST_PD_FRAME_END: assert property ($changed(chanPowerDown) |-> spiCsN && $past(spiCsN))
        else $error("power-down changed without a finished frame");
    AST_LATCH_CAUSE: assert property ($changed(dacLatch) |->
        (!latchLoadStrobePinN || !$past(latchLoadStrobePinN) || spiCsN))
        else $error("latch changed without a load cause");
endmodule // qdc_command_control_chk
bind qdc_command_control qdc_command_control_chk #(.CHANNELS(CHANNELS), .DATA_W(DATA_W)) i_chk (
    .clk(clk), .rst_n(rst_n), .spiSclk(spiSclk), .spiCsN(spiCsN),
    .serialOutPin(serialOutPin), .serialOutEn(serialOutEn),
    .latchLoadStrobePinN(latchLoadStrobePinN), .gpioOut(gpioOut), .gpioOe(gpioOe),
    .dacLatch(dacLatch), .chanPowerDown(chanPowerDown));

// File: verification/qdc_host_model.sv
// Purpose: Host serial master driving 24-bit frames
// Assumes: Serial clock idles low, data taken on its rising edge
// Notes:   halfClk sets serial clock speed in system clocks
`timescale 1ns/10ps
module qdc_host_model (
    // System clock
    input  wire logic clk,
    // Serial link
    output logic      spiSclk,
    output logic      spiCsN,
    output logic      spiSdi,
    input  wire logic sdoLine
);
    int halfClk = 2;
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiSdi = 1'b0;
    end
    // One frame MSB first; rx collects the serial output
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        @(negedge clk) spiCsN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spiSdi = tx[i];
            repeat (halfClk) @(negedge clk);
            rx[i] = sdoLine;
            spiSclk = 1'b1;
            repeat (halfClk) @(negedge clk);
            spiSclk = 1'b0;
        end
        spiSdi = ~spiSdi; // Released line shows no stale value
        spiCsN = 1'b1;
        repeat (8) @(negedge clk); // Gap lets the update land
    endtask
endmodule // qdc_host_model

// File: verification/tb_top.sv
// Purpose: Self-checking bench for the command control block
// Assumes: Pull-ups on the general-purpose pins
// Notes:   Reads take two frames, data returns in the second
`timescale 1ns/10ps
`include "qdc_params.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n, sclk, csN, sdi, sdoPin, sdoEn, strobeN, lastSdo;
    logic [1:0] gpioIn, gpioOut, gpioOe, extLow;
    logic [3:0][15:0] dacLatch;
    logic [3:0] pd;
    logic [15:0] v;
    logic [15:0] vals [4] = '{16'h1003, 16'h2227, 16'h4442, 16'h8881};
    logic [15:0] pdW [3] = '{16'h1300, 16'h0B00, 16'h0300};
    logic [3:0] pdE [3] = '{4'h3, 4'hC, 4'h0};
    int miscompares = 0;
    int nCompared = 0;
    // Clock, open-drain pins and released serial line
    always #12.5 clk = ~clk;
    assign gpioIn = ((gpioOe & gpioOut) | ~gpioOe) & ~extLow;
    always @(posedge clk) if (sdoEn) lastSdo <= sdoPin;
    wire sdoLine = sdoEn ? sdoPin : ~lastSdo;
    qdc_command_control #(.CHANNELS(4), .DATA_W(16)) i_dut (
        .clk(clk), .rst_n(rst_n), .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi),
        .serialOutPin(sdoPin), .serialOutEn(sdoEn), .latchLoadStrobePinN(strobeN),
        .gpioIn(gpioIn), .gpioOut(gpioOut), .gpioOe(gpioOe), .dacLatch(dacLatch),
        .chanPowerDown(pd));
    qdc_host_model i_host (.clk(clk), .spiSclk(sclk), .spiCsN(csN), .spiSdi(sdi),
        .sdoLine(sdoLine));
    // Compare and report
    task automatic check(input logic [67:0] seen, input logic [67:0] exp);
        nCompared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (miscompares == 0 && nCompared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Register access frames
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        qdc_pkg::qdc_frame_s f;
        logic [23:0] rx;
        f = '{1'b0, 3'h0, a, d};
        i_host.xfer(f, rx);
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        qdc_pkg::qdc_frame_s f;
        logic [23:0] rx;
        f = '{1'b1, 3'h0, a, 16'h0};
        i_host.xfer(f, rx);
        i_host.xfer(f, rx);
        d = rx[23:8];
    endtask
    // Watchdog
    initial begin
        repeat (60000) @(posedge clk);
        miscompares++;
        summarize();
    end
    // Main sequence
    initial begin
        rst_n = 1'b0;
        strobeN = 1'b1;
        extLow = 2'b00;
        lastSdo = 1'b0;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        rd(`QDC_ADDR_CMD, v); check(v, 16'h033C);
        for (int c = 0; c < 4; c++) wr(`QDC_ADDR_DAC0 + 4'(c), vals[c]);
        for (int c = 0; c < 4; c++) begin
            rd(`QDC_ADDR_DAC0 + 4'(c), v); check(v, vals[c] & 16'hFFFC);
        end
        check(dacLatch, 64'h0);
        wr(`QDC_ADDR_CMD, 16'h4300); check(dacLatch, 64'h8880444022241000);
        rd(`QDC_ADDR_CMD, v); check(v, 16'h0300);
        wr(`QDC_ADDR_DAC0 + 4'h2, 16'h1234);
        wr(`QDC_ADDR_CMD, 16'h8300);
        i_host.halfClk = 5;
        rd(`QDC_ADDR_DAC0 + 4'h2, v); check(v, 16'h4440);
        i_host.halfClk = 2;
        wr(`QDC_ADDR_CMD, 16'h0300);
        rd(`QDC_ADDR_DAC0 + 4'h2, v); check(v, 16'h1234);
        wr(`QDC_ADDR_CMD, 16'h4300); check(dacLatch, 64'h8880123422241000);
        for (int k = 0; k < 3; k++) begin
            wr(`QDC_ADDR_CMD, pdW[k]); check(pd, pdE[k]);
        end
        wr(`QDC_ADDR_CMD, 16'h0700); rd(`QDC_ADDR_CMD, v); check(v, 16'h0300);
        wr(`QDC_ADDR_CMD, 16'h0100); check(gpioOe, 2'b10);
        rd(`QDC_ADDR_CMD, v); check(v, 16'h0100);
        extLow = 2'b01;
        rd(`QDC_ADDR_CMD, v); check(v, 16'h0000);
        extLow = 2'b00;
        strobeN = 1'b0;
        wr(`QDC_ADDR_CMD, 16'h4300); rd(`QDC_ADDR_CMD, v); check(v, 16'h0300);
        wr(`QDC_ADDR_DAC0, 16'h0F0C); check(dacLatch, 64'h8880123422240F0C);
        strobeN = 1'b1;
        wr(`QDC_ADDR_CMD, 16'h1B00);
        wr(`QDC_ADDR_CMD, 16'h2300); check({pd, dacLatch}, 68'h0);
        rd(`QDC_ADDR_CMD, v); check(v, 16'h033C);
        rd(`QDC_ADDR_DAC0, v); check(v, 16'h0000);
        summarize();
    end
endmodule // tb_top
